// *** core/ics_cfg.svh ***
// Constants of the two-wire slave and crystal-loop status block
`ifndef ICS_CFG_SVH
`define ICS_CFG_SVH
`define ICS_ADDR_HI       3'h5
`define ICS_ADDR_LO       2'h0
`define ICS_NREGS         8
`define ICS_REG_STAT      3'h7
`define ICS_REG_XLOOP     3'h6
`define ICS_STAT1_BIT     7
`define ICS_STAT0_BIT     6
`define ICS_CMOS_BIT      4
`define ICS_PUMP_DIS_BIT  7
`define ICS_XLCTL_HI      3
`define ICS_XLCTL_LO      1
`define ICS_XLCTL_OFF     3'h1
`define ICS_REG_RESET     8'h00
`define ICS_FILT_LEN      3
`endif

// *** core/ics_pkg.sv ***
// Types of the two-wire slave block
package ics_pkg;
  typedef enum logic [5:0] {
    ICS_IDLE  = 6'b00_0001,
    ICS_DADR  = 6'b00_0010,
    ICS_PTR   = 6'b00_0100,
    ICS_WDAT  = 6'b00_1000,
    ICS_RDAT  = 6'b01_0000,
    ICS_IGN   = 6'b10_0000
  } ics_state_e;
  typedef logic [7:0] ics_byte_t;
endpackage : ics_pkg

// *** core/ics_pin_filter.sv ***
// Two-flop synchroniser with an all-samples-equal glitch filter
`timescale 1ns/1ps
`default_nettype none
`include "ics_cfg.svh"
module ics_pin_filter
  import ics_pkg::*;
#(
  parameter int unsigned FILT_LEN = `ICS_FILT_LEN
) (
  // Clock and reset
  input  wire logic mclk_i,
  input  wire logic rst_n_i,
  // Pin in, clean level out
  input  wire logic pin_i,
  output logic      level_o
);
  logic       sync1_q;
  logic       sync2_q;
  logic [FILT_LEN-1:0] hist_q;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
    end else begin
      sync1_q <= pin_i;
      sync2_q <= sync1_q;
    end
  end

  // Level changes only after FILT_LEN equal samples, so short spikes die here
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hist_q  <= '1;
      level_o <= 1'b1;
    end else begin
      hist_q <= {hist_q[FILT_LEN-2:0], sync2_q};
      if (&hist_q) begin
        level_o <= 1'b1;
      end else if (~|hist_q) begin
        level_o <= 1'b0;
      end
    end
  end
endmodule : ics_pin_filter
`default_nettype wire

// *** core/ics_slave.sv ***
// Two-wire slave with eight config registers and crystal-loop status
`timescale 1ns/1ps
`default_nettype none
`include "ics_cfg.svh"
module ics_slave
  import ics_pkg::*;
#(
  parameter int unsigned NREGS = `ICS_NREGS
) (
  // Clock and reset
  input  wire logic       mclk_i,
  input  wire logic       reset_n_i,
  // Serial bus pins
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  input  wire logic       addr_sel_i,
  // Crystal loop status in
  input  wire logic       xl_locked_i,
  input  wire logic       xl_range_high_i,
  // Lock / current-program pin
  output logic            lock_pin_o,
  output logic            lock_pin_oe_o,
  // Controls out
  output logic            crystal_loop_pump_disable_o,
  output logic            crystal_osc_shutdown_o,
  output logic            lock_error_o,
  output logic [8*NREGS-1:0] regs_o
);
  ////////////////////////////////////////////////////////////////////////
  // Reset release and pin conditioning
  logic rst_s1_q;
  logic rst_n;
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  logic scl;
  logic sda;
  logic addr_sel;
  ics_pin_filter u_scl (.mclk_i(mclk_i), .rst_n_i(rst_n), .pin_i(scl_i), .level_o(scl));
  ics_pin_filter u_sda (.mclk_i(mclk_i), .rst_n_i(rst_n), .pin_i(sda_i), .level_o(sda));
  ics_pin_filter u_adr (.mclk_i(mclk_i), .rst_n_i(rst_n), .pin_i(addr_sel_i),
                        .level_o(addr_sel));

  ////////////////////////////////////////////////////////////////////////
  // Bus event detection
  logic scl_q;
  logic sda_q;
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end
  wire start_ev = scl && scl_q && sda_q && !sda;
  wire stop_ev  = scl && scl_q && !sda_q && sda;
  wire scl_rise = scl && !scl_q;
  wire scl_fall = !scl && scl_q;

  ////////////////////////////////////////////////////////////////////////
  // Byte engine
  ics_state_e state_q;
  logic [3:0] bit_cnt_q;
  ics_byte_t  shift_q;
  ics_byte_t  tx_q;
  logic       ack_phase_q;
  logic       drive_ack_q;
  logic       mst_nack_q;
  logic [2:0] ptr_q;
  ics_byte_t  regs_q [NREGS];
  logic       lock_flag;
  logic       range_dir_q;
  // Address match, held from the eighth rise to the ack decision
  logic       addr_hit_q;

  // Received byte including the bit sampled this edge
  wire ics_byte_t rx_byte = {shift_q[6:0], sda};
  wire addr_hit = (rx_byte[7:5] == `ICS_ADDR_HI) && (rx_byte[4] == 1'b1) &&
                  (rx_byte[3] == addr_sel) && (rx_byte[2:1] == `ICS_ADDR_LO);

  function automatic ics_byte_t read_reg(input logic [2:0] idx);
    ics_byte_t v;
    v = regs_q[idx];
    // live lock flag, or range direction if bit 6 is set, replaces status bit 7 while it is clear
    if (idx == `ICS_REG_STAT && !v[`ICS_STAT1_BIT]) begin
      v[`ICS_STAT1_BIT] = v[`ICS_STAT0_BIT] ? range_dir_q : lock_flag;
    end
    return v;
  endfunction : read_reg

  wire bit8 = (bit_cnt_q == 4'd7);
  logic wr_en;
  always_comb begin
    // update at the eighth clock rise of each data byte
    wr_en = scl_rise && !ack_phase_q && bit8 && (state_q == ICS_WDAT);
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_q     <= ICS_IDLE;
      bit_cnt_q   <= 4'd0;
      shift_q     <= 8'h00;
      ack_phase_q <= 1'b0;
      drive_ack_q <= 1'b0;
      mst_nack_q  <= 1'b0;
      ptr_q       <= 3'd0;
    end else if (start_ev) begin
      state_q     <= ICS_DADR;
      bit_cnt_q   <= 4'd0;
      ack_phase_q <= 1'b0;
      drive_ack_q <= 1'b0;
      mst_nack_q  <= 1'b0;
    end else if (stop_ev) begin
      state_q     <= ICS_IDLE;
      bit_cnt_q   <= 4'd0;
      ack_phase_q <= 1'b0;
      drive_ack_q <= 1'b0;
    end else if (scl_rise && state_q != ICS_IDLE && state_q != ICS_IGN) begin
      if (ack_phase_q) begin
        if (state_q == ICS_RDAT) begin
          mst_nack_q <= sda;
        end
      end else begin
        shift_q   <= rx_byte;
        bit_cnt_q <= bit8 ? 4'd8 : bit_cnt_q + 4'd1;
      end
    end else if (scl_fall) begin
      if (bit_cnt_q == 4'd8) begin
        // Enter the ninth clock
        bit_cnt_q   <= 4'd0;
        ack_phase_q <= 1'b1;
        case (state_q)
          ICS_DADR: begin
            drive_ack_q <= addr_hit_q;
            if (!addr_hit_q) begin
              state_q <= ICS_IGN;
            end
          end
          ICS_PTR:  drive_ack_q <= 1'b1;
          ICS_WDAT: drive_ack_q <= 1'b1;
          ICS_RDAT: drive_ack_q <= 1'b0;
          default:  drive_ack_q <= 1'b0;
        endcase
        if (state_q == ICS_PTR) begin
          ptr_q <= shift_q[2:0];
        end
        if (state_q == ICS_WDAT || state_q == ICS_RDAT) begin
          ptr_q <= ptr_q + 3'd1;
        end
      end else if (ack_phase_q) begin
        ack_phase_q <= 1'b0;
        drive_ack_q <= 1'b0;
        case (state_q)
          ICS_DADR: state_q <= shift_q[0] ? ICS_RDAT : ICS_PTR;
          ICS_PTR:  state_q <= ICS_WDAT;
          ICS_RDAT: state_q <= mst_nack_q ? ICS_IGN : ICS_RDAT;
          default:  state_q <= state_q;
        endcase
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      addr_hit_q <= 1'b0;
    end else if (scl_rise && bit8 && !ack_phase_q && state_q == ICS_DADR) begin
      addr_hit_q <= addr_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register bank
  // zero at reset
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NREGS; i++) begin
        regs_q[i] <= `ICS_REG_RESET;
      end
    end else if (wr_en) begin
      regs_q[ptr_q] <= rx_byte;
    end
  end

  // Transmit shifter: load at address ack end or after each read ack
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      tx_q <= 8'hFF;
    end else if (scl_fall && ack_phase_q) begin
      tx_q <= read_reg(ptr_q);
    end else if (scl_fall && state_q == ICS_RDAT && !ack_phase_q && bit_cnt_q != 4'd8) begin
      tx_q <= {tx_q[6:0], 1'b1};
    end
  end

  // Open drain: only ever pulls low
  always_comb begin
    sda_o    = 1'b0;
    sda_oe_o = 1'b0;
    if (ack_phase_q) begin
      sda_oe_o = drive_ack_q;
    end else if (state_q == ICS_RDAT) begin
      // Each bit stays on the line until the filtered fall; letting go at
      // the eighth rise would cut the last bit short of the master's sample,
      // since our view of the clock lags the pin by the filter delay
      // high bits and nack leave line released
      sda_oe_o = !tx_q[7];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Crystal-loop status
  logic lk_s1_q;
  logic rh_s1_q;
  logic rh_s2_q;
  logic lk_prev_q;
  logic lock_err_q;
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      lk_s1_q   <= 1'b0;
      lock_flag <= 1'b0;
      rh_s1_q   <= 1'b0;
      rh_s2_q   <= 1'b0;
      lk_prev_q <= 1'b0;
    end else begin
      lk_s1_q   <= xl_locked_i;
      lock_flag <= lk_s1_q;
      rh_s1_q   <= xl_range_high_i;
      rh_s2_q   <= rh_s1_q;
      lk_prev_q <= lock_flag;
    end
  end
  // direction latched on loss of lock
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      range_dir_q <= 1'b0;
    end else if (lk_prev_q && !lock_flag) begin
      range_dir_q <= rh_s2_q;
    end
  end
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      lock_err_q <= 1'b0;
    end else begin
      lock_err_q <= !lock_flag;
    end
  end
  assign lock_error_o = lock_err_q;

  ics_byte_t stat_r;
  always_comb begin
    stat_r        = regs_q[`ICS_REG_STAT];
    lock_pin_oe_o = stat_r[`ICS_CMOS_BIT];
    case (stat_r[`ICS_STAT1_BIT:`ICS_STAT0_BIT])
      2'b00:   lock_pin_o = lock_flag;
      2'b01:   lock_pin_o = range_dir_q;
      default: lock_pin_o = 1'b0;
    endcase
  end

  assign crystal_loop_pump_disable_o = regs_q[`ICS_REG_XLOOP][`ICS_PUMP_DIS_BIT];
  assign crystal_osc_shutdown_o =
    (regs_q[`ICS_REG_XLOOP][`ICS_XLCTL_HI:`ICS_XLCTL_LO] == `ICS_XLCTL_OFF);
  // port logic needs no crystal clock
  genvar g;
  generate
    for (g = 0; g < NREGS; g++) begin : g_regs
      assign regs_o[8*g +: 8] = regs_q[g];
    end
  endgenerate
endmodule : ics_slave
`default_nettype wire

// *** testbench/ics_slave_asserts.sv ***
// Port-level assertions for the two-wire slave
`timescale 1ns/1ps
`default_nettype none
module ics_slave_asserts #(
  parameter int unsigned NREGS = 8
) (
  // Clock, reset and pins
  input wire logic               mclk_i,
  input wire logic               reset_n_i,
  input wire logic               scl_i,
  input wire logic               sda_i,
  input wire logic               sda_o,
  input wire logic               sda_oe_o,
  input wire logic               addr_sel_i,
  input wire logic               xl_locked_i,
  input wire logic               xl_range_high_i,
  input wire logic               lock_pin_o,
  input wire logic               lock_pin_oe_o,
  // Controls
  input wire logic               crystal_loop_pump_disable_o,
  input wire logic               crystal_osc_shutdown_o,
  input wire logic               lock_error_o,
  input wire logic [8*NREGS-1:0] regs_o
);
  default clocking @(posedge mclk_i);
  endclocking
  default disable iff (!reset_n_i);
  ////////////////////////////////////////////////////////////////
  a_open_drain: assert property (sda_o == 1'b0)
    else $error("data pin driven high");
  a_pump_bit: assert property (crystal_loop_pump_disable_o == regs_o[55])
    else $error("pump disable mismatch");
  a_osc_off: assert property (crystal_osc_shutdown_o == (regs_o[51:49] == 3'h1))
    else $error("oscillator shutdown mismatch");
  a_pin_enable: assert property (lock_pin_oe_o == regs_o[60])
    else $error("lock pin enable mismatch");
  a_pin_unlocked: assert property (
    (lock_pin_oe_o && regs_o[63:62] == 2'b00 && !xl_locked_i)[*8] |-> !lock_pin_o)
    else $error("lock pin high while unlocked");
  a_lock_error: assert property ((!xl_locked_i)[*8] |-> lock_error_o)
    else $error("lock error not raised");
  a_reset_clear: assert property ($rose(reset_n_i) |-> regs_o == '0)
    else $error("registers not clear after reset");
  a_update_ack: assert property (!$stable(regs_o) |-> ##[1:24] sda_oe_o)
    else $error("register update without acknowledge");
  // Once the clock has been high for three cycles, the data drive must not move
  a_hold_high: assert property (scl_i[*3] |-> $stable(sda_oe_o))
    else $error("data drive moved while clock high");
  c_ack: cover property ($rose(sda_oe_o));
  c_pump: cover property ($rose(crystal_loop_pump_disable_o));
  c_unlock: cover property ($fell(lock_pin_o));
endmodule : ics_slave_asserts
`default_nettype wire

// *** testbench/ics_master_model.sv ***
// Two-wire bus master model for the slave's serial pins
`timescale 1ns/1ps
`default_nettype none
module ics_master_model (
  // Clock and wired data line
  input  wire logic mclk_i,
  input  wire logic sda_i,
  // Clock out, open-drain data pull
  output logic      scl_o,
  output logic      sda_low_o
);
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : tick
  task automatic start();
    tick(2);
    sda_low_o = 1'b0;
    tick(6);
    scl_o = 1'b1;
    tick(8);
    sda_low_o = 1'b1;
    tick(8);
    scl_o = 1'b0;
  endtask : start
  // stop leaves both lines idle high
  task automatic stop();
    tick(2);
    sda_low_o = 1'b1;
    tick(6);
    scl_o = 1'b1;
    tick(8);
    sda_low_o = 1'b0;
    tick(8);
  endtask : stop
  // data moves only while the clock is low
  task automatic bit_x(input logic b, output logic r);
    tick(2);
    sda_low_o = !b;
    tick(6);
    scl_o = 1'b1;
    tick(7);
    r = sda_i;
    tick(1);
    scl_o = 1'b0;
  endtask : bit_x
  task automatic xfer(input logic [7:0] d, input int nb, output logic [7:0] r);
    r = 8'h00;
    for (int i = 7; i > 7 - nb; i--) bit_x(d[i], r[i]);
  endtask : xfer
endmodule : ics_master_model
`default_nettype wire

// *** testbench/ics_slave_bench.sv ***
// Self-checking bench for the two-wire slave
`timescale 1ns/1ps
`default_nettype none
module ics_slave_bench;
  logic        mclk_i = 1'b0;
  logic        reset_n_i, scl_i, sda_i, sda_o, sda_oe_o, addr_sel_i, m_low;
  logic        xl_locked_i, xl_range_high_i, lock_pin_o, lock_pin_oe_o, lock_error_o;
  logic        crystal_loop_pump_disable_o, crystal_osc_shutdown_o;
  logic [63:0] regs_o;
  logic [7:0]  q;
  int          bad_count = 0;
  int          checked = 0;
  // Pull-up: released line reads high
  assign sda_i = !(m_low || (sda_oe_o && !sda_o));
  always #12.5 mclk_i = ~mclk_i;
  ics_master_model m (.mclk_i, .sda_i, .scl_o(scl_i), .sda_low_o(m_low));
  ics_slave dut (.mclk_i, .reset_n_i, .scl_i, .sda_i, .sda_o, .sda_oe_o, .addr_sel_i,
    .xl_locked_i, .xl_range_high_i, .lock_pin_o, .lock_pin_oe_o, .lock_error_o,
    .crystal_loop_pump_disable_o, .crystal_osc_shutdown_o, .regs_o);
  ////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic wb(input logic [7:0] d, input logic ea);
    logic a;
    m.xfer(d, 8, q);
    m.bit_x(1'b1, a);
    check("ack", a, ea);
  endtask : wb
  task automatic rb(input logic last, input logic [7:0] e);
    logic a;
    m.xfer(8'hff, 8, q);
    m.bit_x(last, a);
    check("read", q, e);
  endtask : rb
  task automatic setp(input logic [7:0] p);
    m.start();
    wb(8'hb0, 1'b0);
    wb(p, 1'b0);
  endtask : setp
  task automatic rreg(input logic [7:0] p, input logic [7:0] e);
    setp(p);
    m.start();
    wb(8'hb1, 1'b0);
    rb(1'b1, e);
    m.stop();
  endtask : rreg
  task automatic stop_test();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test
  initial begin
    #1_000_000;
    bad_count++;
    stop_test();
  end
  initial begin
    reset_n_i = 1'b0;
    addr_sel_i = 1'b0;
    xl_locked_i = 1'b1;
    xl_range_high_i = 1'b0;
    m.tick(16);
    reset_n_i = 1'b1;
    m.tick(20);
    check("reset", regs_o, 64'h0);
    for (int s = 0; s < 2; s++) begin
      addr_sel_i = s[0];
      m.start();
      wb({4'hb, ~s[0], 3'h0}, 1'b1);
      m.start();
      wb(8'h00, 1'b1);
      m.start();
      wb({4'hb, s[0], 3'h0}, 1'b0);
      m.stop();
    end
    addr_sel_i = 1'b0;
    setp(8'h06);
    wb(8'h82, 1'b0);
    check("pump", {crystal_loop_pump_disable_o, crystal_osc_shutdown_o}, 2'h3);
    wb(8'h10, 1'b0);
    for (int i = 0; i < 6; i++) wb(8'ha0 + 8'(i), 1'b0);
    wb(8'h04, 1'b0);
    m.stop();
    check("wrap", regs_o, 64'h1004_a5a4_a3a2_a1a0);
    check("pump", {crystal_loop_pump_disable_o, crystal_osc_shutdown_o}, 2'h0);
    setp(8'h05);
    m.start();
    wb(8'hb1, 1'b0);
    rb(1'b0, 8'ha5);
    rb(1'b0, 8'h04);
    rb(1'b0, 8'h90);
    rb(1'b1, 8'ha0);
    m.stop();
    check("release", sda_oe_o, 1'b0);
    setp(8'h02);
    m.xfer(8'h55, 5, q);
    m.start();
    wb(8'hb1, 1'b0);
    rb(1'b1, 8'ha2);
    m.stop();
    check("pin", {lock_pin_oe_o, lock_pin_o, lock_error_o}, 3'h6);
    xl_locked_i = 1'b0;
    m.tick(20);
    check("unlock", {lock_pin_o, lock_error_o}, 2'h1);
    rreg(8'h07, 8'h10);
    xl_locked_i = 1'b1;
    xl_range_high_i = 1'b1;
    setp(8'h07);
    wb(8'h50, 1'b0);
    m.stop();
    xl_locked_i = 1'b0;
    m.tick(20);
    xl_range_high_i = 1'b0;
    m.tick(20);
    check("range", lock_pin_o, 1'b1);
    rreg(8'h07, 8'hd0);
    stop_test();
  end
endmodule : ics_slave_bench
bind ics_slave ics_slave_asserts #(.NREGS(NREGS)) u_chk (.mclk_i, .reset_n_i, .scl_i,
  .sda_i, .sda_o, .sda_oe_o, .addr_sel_i, .xl_locked_i, .xl_range_high_i, .lock_pin_o,
  .lock_pin_oe_o, .crystal_loop_pump_disable_o, .crystal_osc_shutdown_o, .lock_error_o,
  .regs_o);
`default_nettype wire
